/* src/mds_carrier.sv */
// triangular carrier and three-phase compare for one motor
`timescale 1ns/10ps
`include "mds_consts.svh"

module mds_carrier #(
    parameter int HALF_CYC = `MDS_CARRIER_HALF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic drive_en,
    input wire logic hw_estop,
    input wire mds_pkg::mds_phase_t v_cmd,
    input wire logic [11:0] vdc,
    output logic [2:0] pwm,
    output logic [2:0] pwm_oe,
    output logic tick
);

    localparam logic [`MDS_CNT_W-1:0] HALF = `MDS_CNT_W'(HALF_CYC);

    typedef struct packed {
        logic [`MDS_CNT_W-1:0] cnt;
        logic down;
        logic [2:0][`MDS_CNT_W-1:0] cmp;
        logic [2:0] pwm;
        logic tick;
    } mds_car_state_t;

    mds_car_state_t s_q;
    mds_car_state_t s_d;
    logic [2:0][11:0] v_arr;
    logic [2:0][`MDS_CNT_W-1:0] cmp_new;

    assign v_arr = {v_cmd.u, v_cmd.v, v_cmd.w};

    // modulation factor m = v / e in q1.15, then compare = m * half period
    always_comb begin
        logic [26:0] m_wide;
        logic [15:0] m;
        logic [28:0] prod;
        m_wide = '0;
        m = '0;
        prod = '0;
        for (int i = 0; i < 3; i++) begin
            // zero bus voltage would divide by zero: treat as full modulation
            m_wide = (vdc == 12'h000) ? 27'(`MDS_M_ONE) : ({v_arr[i], 15'h0000} / 27'(vdc));
            m = (m_wide > 27'(`MDS_M_ONE)) ? `MDS_M_ONE : m_wide[15:0];
            prod = 29'(m) * 29'(HALF);
            cmp_new[i] = prod[`MDS_M_FRAC +: `MDS_CNT_W];
        end
    end

    // up/down counter, compare reload at the valley, registered pulse outputs
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!s_q.down) begin
            if (s_q.cnt == HALF - `MDS_CNT_W'(1)) begin
                s_d.down = 1'b1;
            end
            s_d.cnt = s_q.cnt + `MDS_CNT_W'(1);
        end else begin
            if (s_q.cnt == `MDS_CNT_W'(1)) begin
                s_d.down = 1'b0;
            end
            s_d.cnt = s_q.cnt - `MDS_CNT_W'(1);
        end
        // reload only at the valley so a pulse is never cut mid-period
        if (s_d.cnt == '0) begin
            s_d.cmp = cmp_new;
            s_d.tick = 1'b1;
        end
        for (int i = 0; i < 3; i++) begin
            // on while command exceeds carrier, off otherwise
            s_d.pwm[i] = drive_en && (s_q.cmp[i] > s_q.cnt);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pwm = s_q.pwm;
    assign tick = s_q.tick;
    // estop releases the pins in the same cycle, no flop in the way
    assign pwm_oe = (drive_en && !hw_estop) ? 3'b111 : 3'b000;

endmodule

/* src/mds_consts.svh */
// constants of the motor drive supervisor: timing counts, limits and codes
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH

// clock rate and tick periods
`define MDS_CLK_MHZ 200
`define MDS_CARRIER_US 50
`define MDS_SLOW_US 500
// carrier period in cycles; the triangle climbs for half of it and falls for the other half
`define MDS_CARRIER_CYC (`MDS_CARRIER_US * `MDS_CLK_MHZ)
`define MDS_CARRIER_HALF (`MDS_CARRIER_CYC / 2)
`define MDS_SLOW_CYC (`MDS_SLOW_US * `MDS_CLK_MHZ)

// widths
`define MDS_CNT_W 13
`define MDS_SLOW_W 17
`define MDS_MOTORS 4

// adc scaling: current code 0x000..0xfff is -12.5 A..+12.5 A, zero at mid scale
`define MDS_CUR_ZERO 12'h800
// bus voltage code 0x000..0xfff is 0 V..111 V
// 28 V is code 1032.97: anything above code 1032 is over 28 V
`define MDS_OV_CODE 12'h408
// 14 V is code 516.49: anything below code 517 is under 14 V
`define MDS_UV_CODE 12'h205
// speed limit 3000 rpm
`define MDS_SPEED_LIM 16'h0bb8

// over-current code per mA of rms nominal current, scaled by 2^16:
// sqrt(2) * 4096 / 25000 mA * 2^16 = 15185
`define MDS_OC_SCALE 16'h3b51
`define MDS_OC_SHIFT 16

// modulation factor is unsigned q1.15; full scale 1.0
`define MDS_M_FRAC 15
`define MDS_M_ONE 16'h8000

// run sequence lengths in slow ticks
`define MDS_OFFSET_TICKS 4'h4
`define MDS_STARTUP_TICKS 4'h8

`endif

/* src/mds_pkg.sv */
// types of the motor drive supervisor
package mds_pkg;

    typedef enum logic [1:0] {
        MDS_SYS_INACTIVE = 2'b00,
        MDS_SYS_ACTIVE = 2'b01,
        MDS_SYS_ERROR = 2'b10
    } mds_sys_mode_t;

    typedef enum logic [1:0] {
        MDS_RUN_OFFSET = 2'b00,
        MDS_RUN_STARTUP = 2'b01,
        MDS_RUN_SENSORLESS = 2'b10
    } mds_run_mode_t;

    typedef struct packed {
        logic ev_active;
        logic ev_inactive;
        logic ev_reset;
    } mds_event_t;

    typedef struct packed {
        logic [11:0] u;
        logic [11:0] v;
        logic [11:0] w;
    } mds_phase_t;

    typedef struct packed {
        logic hw_oc;
        logic sw_oc;
        logic ov;
        logic uv;
        logic os;
    } mds_fault_t;

    typedef struct packed {
        mds_event_t ev;
        mds_phase_t cur;
        mds_phase_t v_cmd;
        logic [11:0] vdc;
        logic signed [15:0] speed;
        logic hw_estop;
    } mds_motor_in_t;

    typedef struct packed {
        mds_sys_mode_t sys_mode;
        mds_run_mode_t run_mode;
        mds_fault_t fault;
        logic [2:0] pwm;
        logic [2:0] pwm_oe;
        logic carrier_tick;
        logic slow_tick;
    } mds_motor_out_t;

    typedef struct packed {
        mds_sys_mode_t sys_mode;
        mds_run_mode_t run_mode;
        logic [3:0] run_cnt;
        mds_fault_t fault;
    } mds_chan_t;

endpackage

/* src/mds_supervisor.sv */
// four-channel motor drive supervisor: modes, protection and pwm carriers
`timescale 1ns/10ps
`include "mds_consts.svh"

// Summary of operation
// - phase output is on while command exceeds the carrier, off while below
// - duty is on-time fraction of a carrier period; compare set for wanted duty
// - modulation factor is voltage command divided by measured bus voltage
// - system mode has three states: inactive, active and error
// - user gives inactive, active, reset events; faults raise the error event
// - run mode steps through its sequence in order, only while active
// - each motor keeps its own system and run mode state
// - hardware over-current stop releases all pwm pins of that drive at once
// - each 50 us tick, phase currents above sqrt(2) times the nominal rms current setting force emergency stop
// - software current limit is derived from the nominal rms current setting
// - each monitoring tick, bus voltage above 28 V stops as over-voltage
// - each monitoring tick, bus voltage below 14 V stops as under-voltage
// - each monitoring tick, speed beyond 3000 rpm stops as over-speed
// - every fault stops the affected motor and records which fault happened
// - work runs on a 50 us carrier tick and a 500 us slow tick
// - each motor has its own carrier tick; one slow tick serves all four
// - bus voltage sample is 12 bits, 0 V to 111 V
// - phase current samples are 12 bits, -12.5 A to +12.5 A
module mds_supervisor #(
    parameter int CARRIER_HALF_CYC = `MDS_CARRIER_HALF,
    parameter int SLOW_CYC = `MDS_SLOW_CYC
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] nominal_current_rms_param,
    input wire mds_pkg::mds_motor_in_t [`MDS_MOTORS-1:0] motor_in,
    output mds_pkg::mds_motor_out_t [`MDS_MOTORS-1:0] motor_out
);

    localparam logic [`MDS_SLOW_W-1:0] SLOW_LAST = `MDS_SLOW_W'(SLOW_CYC - 1);

    typedef struct packed {
        logic [`MDS_SLOW_W-1:0] slow_cnt;
        logic slow_tick;
        mds_pkg::mds_chan_t [`MDS_MOTORS-1:0] ch;
    } mds_sup_state_t;

    mds_sup_state_t s_q;
    mds_sup_state_t s_d;

    logic [`MDS_MOTORS-1:0] drive_en;
    logic [`MDS_MOTORS-1:0] car_tick;
    logic [`MDS_MOTORS-1:0][2:0] car_pwm;
    logic [`MDS_MOTORS-1:0][2:0] car_oe;
    logic [27:0] oc_prod;
    logic [11:0] oc_limit;

    // distance of a current code from the zero-ampere code
    function automatic logic [11:0] cur_mag(input logic [11:0] code);
        cur_mag = code[11] ? (code - `MDS_CUR_ZERO) : (`MDS_CUR_ZERO - code);
    endfunction

    // magnitude of a signed speed; -32768 maps to 0x8000, still over the limit
    function automatic logic [15:0] speed_mag(input logic signed [15:0] spd);
        speed_mag = spd[15] ? 16'(-spd) : 16'(spd);
    endfunction

    // current limit follows the nominal rms setting: rms * sqrt2 in adc codes
    assign oc_prod = 28'(nominal_current_rms_param) * 28'(`MDS_OC_SCALE);
    assign oc_limit = oc_prod[`MDS_OC_SHIFT +: 12];

    // one carrier per motor, each giving its own 50 us tick
    generate
        for (genvar g = 0; g < `MDS_MOTORS; g++) begin : g_motor
            assign drive_en[g] = (s_q.ch[g].sys_mode == mds_pkg::MDS_SYS_ACTIVE);

            mds_carrier #(
                .HALF_CYC(CARRIER_HALF_CYC)
            ) u_carrier (
                .sys_clk(sys_clk),
                .rst(rst),
                .drive_en(drive_en[g]),
                .hw_estop(motor_in[g].hw_estop),
                .v_cmd(motor_in[g].v_cmd),
                .vdc(motor_in[g].vdc),
                .pwm(car_pwm[g]),
                .pwm_oe(car_oe[g]),
                .tick(car_tick[g])
            );
        end
    endgenerate

    // next state of the slow tick and of every channel
    always_comb begin
        mds_pkg::mds_fault_t det;
        logic err_ev;
        det = '0;
        err_ev = 1'b0;
        s_d = s_q;

        // shared 500 us tick for all motors
        s_d.slow_tick = 1'b0;
        if (s_q.slow_cnt == SLOW_LAST) begin
            s_d.slow_cnt = '0;
            s_d.slow_tick = 1'b1;
        end else begin
            s_d.slow_cnt = s_q.slow_cnt + `MDS_SLOW_W'(1);
        end

        // each channel runs from its own state and inputs, plus the shared slow tick and current limit
        for (int i = 0; i < `MDS_MOTORS; i++) begin
            det = '0;
            // hardware stop counts at once, whatever the tick
            det.hw_oc = motor_in[i].hw_estop;
            // software checks sample on the motor's carrier tick, only while driving
            if (car_tick[i] && s_q.ch[i].sys_mode == mds_pkg::MDS_SYS_ACTIVE) begin
                det.sw_oc = (cur_mag(motor_in[i].cur.u) > oc_limit) ||
                            (cur_mag(motor_in[i].cur.v) > oc_limit) ||
                            (cur_mag(motor_in[i].cur.w) > oc_limit);
                // bus codes are 12 bits over 0..111 V, so both limits are codes on that scale
                det.ov = (motor_in[i].vdc > `MDS_OV_CODE);
                det.uv = (motor_in[i].vdc < `MDS_UV_CODE);
                det.os = (speed_mag(motor_in[i].speed) > `MDS_SPEED_LIM);
            end
            err_ev = |det;

            // fault record is sticky; a new fault beats a reset in the same cycle
            if (motor_in[i].ev.ev_reset && s_q.ch[i].sys_mode == mds_pkg::MDS_SYS_ERROR) begin
                s_d.ch[i].fault = det;
            end else begin
                s_d.ch[i].fault = s_q.ch[i].fault | det;
            end

            // system mode: error has priority over every user event
            unique case (s_q.ch[i].sys_mode)
                mds_pkg::MDS_SYS_INACTIVE: begin
                    if (err_ev) begin
                        s_d.ch[i].sys_mode = mds_pkg::MDS_SYS_ERROR;
                    end else if (motor_in[i].ev.ev_active && !motor_in[i].ev.ev_inactive) begin
                        s_d.ch[i].sys_mode = mds_pkg::MDS_SYS_ACTIVE;
                    end
                end
                mds_pkg::MDS_SYS_ACTIVE: begin
                    if (err_ev) begin
                        s_d.ch[i].sys_mode = mds_pkg::MDS_SYS_ERROR;
                    end else if (motor_in[i].ev.ev_inactive || motor_in[i].ev.ev_reset) begin
                        s_d.ch[i].sys_mode = mds_pkg::MDS_SYS_INACTIVE;
                    end
                end
                mds_pkg::MDS_SYS_ERROR: begin
                    // only a reset leaves, and not while the hardware stop is still asserted (software checks do not run here)
                    if (motor_in[i].ev.ev_reset && !err_ev) begin
                        s_d.ch[i].sys_mode = mds_pkg::MDS_SYS_INACTIVE;
                    end
                end
                default: begin
                    // illegal code: park in the safe state
                    s_d.ch[i].sys_mode = mds_pkg::MDS_SYS_ERROR;
                end
            endcase

            // run mode: sequence restarts whenever the motor is not driving
            if (s_d.ch[i].sys_mode != mds_pkg::MDS_SYS_ACTIVE) begin
                s_d.ch[i].run_mode = mds_pkg::MDS_RUN_OFFSET;
                s_d.ch[i].run_cnt = '0;
            end else if (s_q.slow_tick) begin
                unique case (s_q.ch[i].run_mode)
                    mds_pkg::MDS_RUN_OFFSET: begin
                        if (s_q.ch[i].run_cnt == `MDS_OFFSET_TICKS - 4'h1) begin
                            s_d.ch[i].run_mode = mds_pkg::MDS_RUN_STARTUP;
                            s_d.ch[i].run_cnt = '0;
                        end else begin
                            s_d.ch[i].run_cnt = s_q.ch[i].run_cnt + 4'h1;
                        end
                    end
                    mds_pkg::MDS_RUN_STARTUP: begin
                        if (s_q.ch[i].run_cnt == `MDS_STARTUP_TICKS - 4'h1) begin
                            s_d.ch[i].run_mode = mds_pkg::MDS_RUN_SENSORLESS;
                            s_d.ch[i].run_cnt = '0;
                        end else begin
                            s_d.ch[i].run_cnt = s_q.ch[i].run_cnt + 4'h1;
                        end
                    end
                    mds_pkg::MDS_RUN_SENSORLESS: begin
                        // final step: stays until the motor leaves active
                        s_d.ch[i].run_cnt = '0;
                    end
                    default: begin
                        s_d.ch[i].run_mode = mds_pkg::MDS_RUN_OFFSET;
                        s_d.ch[i].run_cnt = '0;
                    end
                endcase
            end
        end
    end

    // single register for the whole supervisor state
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // per-motor status and pin outputs
    always_comb begin
        for (int i = 0; i < `MDS_MOTORS; i++) begin
            motor_out[i].sys_mode = s_q.ch[i].sys_mode;
            motor_out[i].run_mode = s_q.ch[i].run_mode;
            motor_out[i].fault = s_q.ch[i].fault;
            motor_out[i].pwm = car_pwm[i];
            motor_out[i].pwm_oe = car_oe[i];
            motor_out[i].carrier_tick = car_tick[i];
            motor_out[i].slow_tick = s_q.slow_tick;
        end
    end

endmodule

/* verification/mds_bridge_model.sv */
// inverter bridge and motor load model for one drive
`timescale 1ns/10ps
module mds_bridge_model (
    input wire logic [2:0] pwm,
    input wire logic [2:0] pwm_oe,
    input wire logic [11:0] amp,
    output mds_pkg::mds_phase_t cur
);
    // a released leg carries no current, so its sensor reads mid scale
    assign cur.u = !pwm_oe[2] ? 12'h800 : pwm[2] ? 12'h800 + amp : 12'h800 - amp;
    assign cur.v = !pwm_oe[1] ? 12'h800 : pwm[1] ? 12'h800 + amp : 12'h800 - amp;
    assign cur.w = !pwm_oe[0] ? 12'h800 : pwm[0] ? 12'h800 + amp : 12'h800 - amp;
endmodule

/* verification/mds_sup_assertions.sv */
// property checker watching the motor drive supervisor ports
`timescale 1ns/10ps
`include "mds_consts.svh"
module mds_sup_assertions #(
    parameter int CARRIER_HALF_CYC = 20,
    parameter int SLOW_CYC = 200
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [11:0] nominal_current_rms_param,
    input wire mds_pkg::mds_motor_in_t [`MDS_MOTORS-1:0] motor_in,
    input wire mds_pkg::mds_motor_out_t [`MDS_MOTORS-1:0] motor_out
);
    localparam int PER = 2 * CARRIER_HALF_CYC;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // motor 0 carries every fault scenario, so its channel is the one watched
    wire mds_pkg::mds_motor_in_t i0 = motor_in[0];
    wire mds_pkg::mds_motor_out_t o0 = motor_out[0];
    wire act0 = o0.sys_mode == mds_pkg::MDS_SYS_ACTIVE;
    wire err0 = o0.sys_mode == mds_pkg::MDS_SYS_ERROR;
    wire chk0 = act0 && o0.carrier_tick;
    // motor 1 stays active long enough to walk the whole run sequence
    wire mds_pkg::mds_motor_out_t o1 = motor_out[1];
    wire act1 = o1.sys_mode == mds_pkg::MDS_SYS_ACTIVE;

    a_oe_release: assert property (o0.pwm_oe == ((act0 && !i0.hw_estop) ? 3'h7 : 3'h0))
        else $error("pwm enable wrong");
    a_estop_error: assert property (i0.hw_estop |=> err0 && o0.fault.hw_oc)
        else $error("hardware stop not latched");
    a_ov_stop: assert property (chk0 && i0.vdc > 12'h408 |=> err0 && o0.fault.ov)
        else $error("over-voltage missed");
    a_uv_stop: assert property (chk0 && i0.vdc < 12'h205 |=> err0 && o0.fault.uv)
        else $error("under-voltage missed");
    a_speed_stop: assert property (chk0 && (i0.speed > 16'sd3000 || i0.speed < -16'sd3000)
        |=> err0 && o0.fault.os)
        else $error("over-speed missed");
    a_error_hold: assert property (err0 && !i0.ev.ev_reset |=> err0)
        else $error("error left without reset");
    a_pwm_idle: assert property (!act0 |=> o0.pwm == 3'h0)
        else $error("pwm on while not driving");
    a_tick_period: assert property (o0.carrier_tick |-> ##PER o0.carrier_tick)
        else $error("carrier tick period wrong");
    a_run_idle: assert property ((!act0) [*2] |-> o0.run_mode == mds_pkg::MDS_RUN_OFFSET)
        else $error("run mode moved while idle");
    a_run_order: assert property (act1 && o1.run_mode != $past(o1.run_mode)
        |-> $past(o1.slow_tick) && o1.run_mode == $past(o1.run_mode) + 2'h1)
        else $error("run mode out of order");
    a_slow_period: assert property (o0.slow_tick |-> ##SLOW_CYC o0.slow_tick)
        else $error("slow tick period wrong");

    c_sw_oc: cover property (err0 && o0.fault.sw_oc);
    c_estop: cover property (act0 && i0.hw_estop);
    c_check: cover property (chk0);
    c_run_done: cover property (act1 && o1.run_mode == mds_pkg::MDS_RUN_SENSORLESS);
endmodule

/* verification/test_mds_supervisor.sv */
// self-checking bench for the motor drive supervisor
`timescale 1ns/10ps
`include "mds_consts.svh"
module test_mds_supervisor;
    localparam int HALF = 20;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] nominal_current_rms_param = 12'h275; // 629 ma gives a 145 code limit
    mds_pkg::mds_motor_in_t [3:0] mb = '0;
    mds_pkg::mds_motor_in_t [3:0] mi;
    mds_pkg::mds_motor_out_t [3:0] mo;
    mds_pkg::mds_phase_t [3:0] cur;
    logic [11:0] amp [4] = '{default: 12'h014};
    logic [6:0] em [4] = '{default: 7'h00};
    logic [27:0] q [$];
    logic [27:0] last = '0;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;

    always #2.5 sys_clk = ~sys_clk;

    mds_supervisor #(.CARRIER_HALF_CYC(HALF), .SLOW_CYC(200)) dut_u (.sys_clk(sys_clk), .rst(rst),
        .nominal_current_rms_param(nominal_current_rms_param), .motor_in(mi), .motor_out(mo));
    for (genvar g = 0; g < 4; g++) begin : g_br
        mds_bridge_model br_u (.pwm(mo[g].pwm), .pwm_oe(mo[g].pwm_oe), .amp(amp[g]), .cur(cur[g]));
    end
    // phase currents come from the bridge models, the rest from the bench
    always_comb begin
        mi = mb;
        for (int k = 0; k < 4; k++) mi[k].cur = cur[k];
    end

    task automatic chk(input string nm, input logic [27:0] seen, input logic [27:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [27:0] st();
        for (int k = 0; k < 4; k++) st[k*7 +: 7] = {mo[k].sys_mode, mo[k].fault};
    endfunction
    task automatic tick();
        do @(posedge sys_clk); while (mo[0].carrier_tick !== 1'b1);
    endtask
    // one-cycle user event; a prediction is queued only when the state should move
    task automatic ev(input int m, input logic [2:0] e, input logic [6:0] nx);
        @(posedge sys_clk);
        mb[m].ev <= e;
        if (nx != em[m]) begin
            em[m] = nx;
            q.push_back({em[3], em[2], em[1], em[0]});
        end
        @(posedge sys_clk);
        mb[m].ev <= 3'h0;
    endtask
    // on cycles per carrier period, counted over the triangle 0..half..1
    function automatic int ontime(input logic [11:0] v, input logic [11:0] e);
        logic [31:0] m;
        int c;
        m = (e == 0) ? 32'h8000 : ({v, 15'h0} / e);
        if (m > 32'h8000) m = 32'h8000;
        c = (m * HALF) >> 15;
        ontime = 0;
        for (int t = 0; t < 2 * HALF; t++) ontime += (((t <= HALF) ? t : 2 * HALF - t) < c);
    endfunction
    task automatic duty();
        int n [3];
        n = '{0, 0, 0};
        tick();
        tick();
        repeat (2 * HALF) begin
            @(negedge sys_clk);
            for (int k = 0; k < 3; k++) n[k] += mo[0].pwm[2-k];
        end
        for (int k = 0; k < 3; k++) chk("pwm_on", 28'(n[k]), 28'(ontime(mb[0].v_cmd[35-12*k -: 12], mb[0].vdc)));
    endtask
    // boundary value first, one code past it next, then reset out of error
    task automatic fcase(input logic [11:0] v0, v1, input logic [15:0] s0, s1, input logic [11:0] a0, a1,
                         input logic [4:0] f);
        @(posedge sys_clk);
        mb[0].vdc <= v0;
        mb[0].speed <= s0;
        amp[0] <= a0;
        ev(0, 3'b100, 7'h20);
        tick();
        tick();
        mb[0].vdc <= v1;
        mb[0].speed <= s1;
        amp[0] <= a1;
        em[0] = {2'b10, f};
        q.push_back({em[3], em[2], em[1], em[0]});
        tick();
        repeat (3) @(posedge sys_clk);
        chk("pwm_off", 28'(mo[0].pwm), 28'h0);
        ev(0, 3'b100, em[0]);
        ev(0, 3'b001, 7'h00);
    endtask

    // every change of mode or fault record must match the oldest prediction
    always @(negedge sys_clk) begin
        if (!rst && st() !== last) begin
            last = st();
            chk("mode_fault", last, (q.size() > 0) ? q.pop_front() : 28'hx);
        end
    end
    // hang guard, well above the roughly 3200 cycles the sequence needs
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(32'hbe0706da));
        mb[1].vdc = 12'h300;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        mb[0].vdc <= 12'h206 + 12'($urandom_range(0, 12'h200));
        mb[0].v_cmd <= {12'($urandom_range(0, 12'h4ff)), 12'($urandom_range(0, 12'h4ff)), 12'h000};
        ev(0, 3'b100, 7'h20);
        ev(1, 3'b100, 7'h20);
        duty();
        chk("pwm_oe", 28'(mo[0].pwm_oe), 28'h7);
        @(posedge sys_clk);
        mb[0].hw_estop <= 1'b1;
        em[0] = 7'h50;
        q.push_back({em[3], em[2], em[1], em[0]});
        @(negedge sys_clk);
        chk("pwm_oe", 28'(mo[0].pwm_oe), 28'h0);
        @(posedge sys_clk);
        mb[0].hw_estop <= 1'b0;
        ev(0, 3'b001, 7'h00);
        fcase(12'h408, 12'h409, 16'h0, 16'h0, 12'h014, 12'h014, 5'h04);
        fcase(12'h205, 12'h204, 16'h0, 16'h0, 12'h014, 12'h014, 5'h02);
        fcase(12'h300, 12'h300, 16'd3000, 16'd3001, 12'h014, 12'h014, 5'h01);
        fcase(12'h300, 12'h300, -16'sd3000, -16'sd3001, 12'h014, 12'h014, 5'h01);
        fcase(12'h300, 12'h300, 16'h0, 16'h0, 12'h091, 12'h092, 5'h08);
        nominal_current_rms_param <= 12'h4e9; // 1257 ma gives a 291 code limit
        fcase(12'h300, 12'h300, 16'h0, 16'h0, 12'h123, 12'h124, 5'h08);
        // motor 1 has been driving since the start; 12 slow ticks take it to the last step
        repeat (2200) @(posedge sys_clk);
        chk("run_mode", 28'(mo[1].run_mode), 28'(mds_pkg::MDS_RUN_SENSORLESS));
        ev(1, 3'b010, 7'h00);
        ev(1, 3'b110, 7'h00);
        repeat (4) @(posedge sys_clk);
        chk("pending", 28'(q.size()), 28'h0);
        complete_run();
    end
endmodule

bind mds_supervisor mds_sup_assertions #(.CARRIER_HALF_CYC(CARRIER_HALF_CYC), .SLOW_CYC(SLOW_CYC)) chk_u (
    .sys_clk(sys_clk), .rst(rst), .nominal_current_rms_param(nominal_current_rms_param),
    .motor_in(motor_in), .motor_out(motor_out));
